//--- rtl/servo_param_pkg.sv
// Constants and carrier types for the servo parameter, fault, jog and I/O register bank.
package servo_param_pkg;

  // ****************************************
  // Register addresses (16-bit word addresses)
  // ****************************************
  localparam logic [15:0] ADDR_FAULT_FIFTH_LO  = 16'h0408;
  localparam logic [15:0] ADDR_FAULT_FIFTH_HI  = 16'h0409;
  localparam logic [15:0] ADDR_JOG_COMMAND     = 16'h040a;
  localparam logic [15:0] ADDR_JOG_COMMAND_HI  = 16'h040b;
  localparam logic [15:0] ADDR_FORCED_OUTPUT   = 16'h040c;
  localparam logic [15:0] ADDR_FORCED_OUTPUT_HI = 16'h040d;
  localparam logic [15:0] ADDR_INPUT_STATUS    = 16'h040e;
  localparam logic [15:0] ADDR_INPUT_STATUS_HI = 16'h040f;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [31:0] FAULT_FIFTH_RESET    = 32'h0000_0000;
  localparam logic [15:0] JOG_COMMAND_RESET    = 16'h0014;
  localparam logic [15:0] FORCED_OUTPUT_RESET  = 16'h0000;
  localparam logic [15:0] SOFT_INPUT_RESET     = 16'h0000;
  localparam logic [15:0] JOG_SPEED_MAX        = 16'h1388;
  localparam logic [15:0] JOG_CODE_FORWARD     = 16'h1386;
  localparam logic [15:0] JOG_CODE_REVERSE     = 16'h1387;
  localparam logic [15:0] JOG_CODE_STOP        = 16'h0000;
  localparam logic [15:0] INPUT_STATUS_MAX     = 16'h3fff;
  localparam logic [7:0]  FORCED_FUNC_BASE     = 8'h30;
  localparam logic [3:0]  FORCED_FUNC_GROUP    = 4'h3;
  localparam int          FAULT_DEPTH          = 5;
  localparam int          OUT_FUNC_W           = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    JOG_IDLE    = 2'b00,
    JOG_FORWARD = 2'b01,
    JOG_REVERSE = 2'b10
  } jog_state_t;

  typedef struct packed {
    logic [15:0] canopen_code;
    logic [15:0] alarm_code;
  } fault_record_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } param_req_t;

  typedef struct packed {
    jog_state_t  dir;
    logic [15:0] speed;
  } jog_drive_t;

endpackage

//--- rtl/servo_param_fault_jog_io_bank.sv
// Register bank for fault history, jog command, forced outputs and input status.
`timescale 1ns/10ps
`default_nettype none

module servo_param_fault_jog_io_bank
  import servo_param_pkg::*;
#(
  parameter int NUM_OUTPUTS = 5,
  parameter int NUM_INPUTS  = 14
) (
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_rst_b,
  input  wire param_req_t                           i_keypad_req,
  input  wire param_req_t                           i_link_req,
  input  wire logic                                 i_fault_push,
  input  wire fault_record_t                        i_fault_code,
  input  wire fault_record_t                        i_fault_fourth,
  input  wire logic                                 i_fault_active,
  input  wire logic [15:0]                          i_rated_speed,
  input  wire logic [NUM_INPUTS-1:0]                i_terminal_inputs,
  input  wire logic [NUM_INPUTS-1:0]                i_input_soft_select,
  input  wire logic [NUM_INPUTS-1:0]                i_jog_forward_sel,
  input  wire logic [NUM_INPUTS-1:0]                i_jog_reverse_sel,
  input  wire logic [NUM_OUTPUTS*OUT_FUNC_W-1:0]    i_output_func_select,
  input  wire logic [NUM_OUTPUTS-1:0]               i_output_normal,
  output logic [15:0]                               o_rdata,
  output logic                                      o_rvalid,
  output jog_drive_t                                o_jog,
  output logic [NUM_OUTPUTS-1:0]                    o_terminal_outputs,
  output logic [NUM_INPUTS-1:0]                     o_input_final,
  output fault_record_t                             o_fault_record_fifth
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NUM_INPUTS-1:0] term_meta;
  logic [NUM_INPUTS-1:0] term_sync;
  logic                  fault_meta;
  logic                  fault_sync;

  // Two stages bound metastability; only the second stage is ever read.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      term_meta <= '0;
      term_sync <= '0;
    end else begin
      term_meta <= i_terminal_inputs;
      term_sync <= term_meta;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end else begin
      fault_meta <= i_fault_active;
      fault_sync <= fault_meta;
    end
  end

  // ****************************************
  // Access arbitration
  // ****************************************
  // Keypad and link share one decode, so both see identical behaviour; the
  // keypad wins a same-cycle collision and the link access is dropped.
  wire         use_keypad = i_keypad_req.wr | i_keypad_req.rd;
  wire param_req_t req    = use_keypad ? i_keypad_req : i_link_req;

  wire hit_fault_lo = req.addr == ADDR_FAULT_FIFTH_LO;
  wire hit_fault_hi = req.addr == ADDR_FAULT_FIFTH_HI;
  wire hit_jog      = req.addr == ADDR_JOG_COMMAND;
  wire hit_jog_hi   = req.addr == ADDR_JOG_COMMAND_HI;
  wire hit_force    = req.addr == ADDR_FORCED_OUTPUT;
  wire hit_force_hi = req.addr == ADDR_FORCED_OUTPUT_HI;
  wire hit_input    = req.addr == ADDR_INPUT_STATUS;
  wire hit_input_hi = req.addr == ADDR_INPUT_STATUS_HI;

  // ****************************************
  // Registers
  // ****************************************
  fault_record_t         fault_fifth;
  logic [15:0]           jog_command;
  logic [15:0]           forced_output_mask;
  logic [15:0]           soft_inputs;
  jog_state_t            jog_state;
  jog_state_t            next_jog_state;
  logic [15:0]           next_jog_command;

  // ****************************************
  // Jog control
  // ****************************************
  wire jog_wr       = req.wr & hit_jog;
  wire jog_is_speed = (req.wdata != JOG_CODE_STOP) && (req.wdata <= JOG_SPEED_MAX)
                      && (req.wdata != JOG_CODE_FORWARD) && (req.wdata != JOG_CODE_REVERSE);
  wire jog_is_fwd   = req.wdata == JOG_CODE_FORWARD;
  wire jog_is_rev   = req.wdata == JOG_CODE_REVERSE;
  wire jog_is_stop  = req.wdata == JOG_CODE_STOP;

  // ****************************************
  // Fault history
  // ****************************************
  // The fourth record shifts down into the fifth when a new fault enters the history.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fault_fifth <= FAULT_FIFTH_RESET;
    end else if (i_fault_push) begin
      fault_fifth <= i_fault_fourth;
    end
  end

  // Codes 4998 and 4999 only act; the stored speed stays as last written.
  assign next_jog_command = (jog_wr && jog_is_speed) ? req.wdata : jog_command;

  wire jog_fwd_in = |(o_input_final & i_jog_forward_sel);
  wire jog_rev_in = |(o_input_final & i_jog_reverse_sel);

  always_comb begin
    next_jog_state = jog_state;
    if (jog_wr && jog_is_fwd) begin
      next_jog_state = JOG_FORWARD;
    end else if (jog_wr && jog_is_rev) begin
      next_jog_state = JOG_REVERSE;
    end else if (jog_wr && jog_is_stop) begin
      next_jog_state = JOG_IDLE;
    // Both jog inputs at once hold the present direction.
    end else if (jog_fwd_in && !jog_rev_in) begin
      next_jog_state = JOG_FORWARD;
    end else if (jog_rev_in && !jog_fwd_in) begin
      next_jog_state = JOG_REVERSE;
    end
    // A fault outranks every request, so it is applied last.
    if (fault_sync) begin
      next_jog_state = JOG_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      jog_command <= JOG_COMMAND_RESET;
    end else begin
      jog_command <= next_jog_command;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      jog_state <= JOG_IDLE;
    end else begin
      jog_state <= next_jog_state;
    end
  end

  wire force_wr = req.wr & hit_force;
  // Out-of-range writes are dropped whole rather than truncated.
  wire input_wr = req.wr & hit_input & (req.wdata <= INPUT_STATUS_MAX);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      forced_output_mask <= FORCED_OUTPUT_RESET;
    end else if (force_wr) begin
      forced_output_mask <= req.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      soft_inputs <= SOFT_INPUT_RESET;
    end else if (input_wr) begin
      soft_inputs <= req.wdata;
    end
  end

  // ****************************************
  // Input merge of terminal and soft inputs
  // ****************************************
  // Bits 0-7 are the base terminals, the rest the extended terminals.
  wire [NUM_INPUTS-1:0] input_final =
    (term_sync & ~i_input_soft_select) | (soft_inputs[NUM_INPUTS-1:0] & i_input_soft_select);

  // ****************************************
  // Output forcing
  // ****************************************
  logic [NUM_OUTPUTS-1:0] output_value;
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      wire [OUT_FUNC_W-1:0] fsel = i_output_func_select[g*OUT_FUNC_W +: OUT_FUNC_W];
      // Only the low byte selects the function; the high byte carries polarity options, which the logic ignores.
      wire forced = fsel[7:4] == FORCED_FUNC_GROUP;
      assign output_value[g] = forced ? forced_output_mask[fsel[3:0]] : i_output_normal[g];
    end
  endgenerate

  // Speed is clamped at the output so a later rise of the rated speed is honoured.
  wire [15:0] jog_speed_eff = (jog_command > i_rated_speed) ? i_rated_speed : jog_command;

  // ****************************************
  // Read data
  // ****************************************
  // High halves of 16-bit parameters and unmapped words read as zero.
  logic [15:0] read_value;

  always_comb begin
    read_value = 16'h0000;
    if (hit_fault_lo) begin
      read_value = fault_fifth.alarm_code;
    end else if (hit_fault_hi) begin
      read_value = fault_fifth.canopen_code;
    end else if (hit_jog) begin
      read_value = jog_command;
    end else if (hit_jog_hi) begin
      read_value = 16'h0000;
    end else if (hit_force) begin
      read_value = forced_output_mask;
    end else if (hit_force_hi) begin
      read_value = 16'h0000;
    end else if (hit_input) begin
      read_value = {{(16-NUM_INPUTS){1'b0}}, input_final};
    end else if (hit_input_hi) begin
      read_value = 16'h0000;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Every output leaves from a flop, so each carries one cycle of latency.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata  <= req.rd ? read_value : 16'h0000;
      o_rvalid <= req.rd;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_jog <= '{dir: JOG_IDLE, speed: 16'h0000};
    end else begin
      o_jog <= '{dir: jog_state, speed: jog_speed_eff};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_terminal_outputs <= '0;
    end else begin
      o_terminal_outputs <= output_value;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_input_final <= '0;
    end else begin
      o_input_final <= input_final;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fault_record_fifth <= FAULT_FIFTH_RESET;
    end else begin
      o_fault_record_fifth <= fault_fifth;
    end
  end

endmodule

`default_nettype wire

//--- sim/servo_param_bank_props.sv
// Port checks for the parameter bank.
`timescale 1ns/10ps
`default_nettype none
module servo_param_bank_props
  import servo_param_pkg::*;
(
  input wire logic          i_core_clk,
  input wire logic          i_rst_b,
  input wire param_req_t    i_keypad_req,
  input wire param_req_t    i_link_req,
  input wire logic          i_fault_push,
  input wire logic          i_fault_active,
  input wire logic [15:0]   i_rated_speed,
  input wire logic [15:0]   o_rdata,
  input wire logic          o_rvalid,
  input wire jog_drive_t    o_jog,
  input wire fault_record_t o_fault_record_fifth
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // The keypad wins a shared edge, so a link read then goes unanswered.
  wire logic kp = i_keypad_req.wr | i_keypad_req.rd;
  wire logic any_rd = i_keypad_req.rd | (i_link_req.rd & !kp);
  wire logic stop_wr = !kp & i_link_req.wr & i_link_req.addr == ADDR_JOG_COMMAND
                       & i_link_req.wdata == JOG_CODE_STOP;
  a_read_answer: assert property (any_rd |=> o_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (o_rvalid |-> $past(any_rd))
    else $error("answer without read");
  a_idle_rdata: assert property (!o_rvalid |-> o_rdata == 16'h0000)
    else $error("read data outside answer");
  a_fifth_moves: assert property ($changed(o_fault_record_fifth) |->
    $past(i_fault_push) || $past(i_fault_push, 2))
    else $error("fifth record moved without push");
  a_fault_halts: assert property (i_fault_active [*5] |-> o_jog.dir == JOG_IDLE)
    else $error("jog runs during fault");
  a_speed_rated: assert property (o_jog.speed <= $past(i_rated_speed))
    else $error("jog speed above rated");
  a_speed_ceiling: assert property (o_jog.speed <= JOG_SPEED_MAX)
    else $error("jog speed above ceiling");
  a_stop_write: assert property (stop_wr |-> ##2 o_jog.dir == JOG_IDLE)
    else $error("jog not stopped");
endmodule
`default_nettype wire

//--- sim/param_host_model.sv
// Host model that issues parameter accesses on one port.
`timescale 1ns/10ps
`default_nettype none
module param_host_model
  import servo_param_pkg::*;
(
  input  wire logic     i_core_clk,
  output var param_req_t o_req
);
  // Jog traffic assumes flash writes were suppressed beforehand.
  initial o_req = '0;
  // A released port shows inverted address and data, never a stale copy.
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

//--- sim/servo_param_fault_jog_io_bank_test.sv
// Bench for the parameter bank.
`timescale 1ns/10ps
`default_nettype none
module servo_param_fault_jog_io_bank_test;
  import servo_param_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  param_req_t i_keypad_req, i_link_req;
  logic i_fault_push = 1'b0;
  logic i_fault_active = 1'b0;
  fault_record_t i_fault_code = '0;
  fault_record_t i_fault_fourth = '0;
  logic [15:0] i_rated_speed = 16'h0bb8;
  logic [13:0] i_terminal_inputs = '0;
  logic [13:0] i_input_soft_select = '0;
  logic [13:0] i_jog_forward_sel = '0;
  logic [13:0] i_jog_reverse_sel = '0;
  logic [79:0] i_output_func_select = 80'h0034_0033_0032_0031_0130;
  logic [4:0] i_output_normal = '0;
  logic [15:0] o_rdata;
  logic o_rvalid;
  jog_drive_t o_jog;
  logic [4:0] o_terminal_outputs;
  logic [13:0] o_input_final;
  fault_record_t o_fault_record_fifth;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h035abe90;
  logic [15:0] mask;
  int mismatches = 0;
  int checks_done = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  param_host_model keypad_host (.i_core_clk, .o_req(i_keypad_req));
  param_host_model link_host (.i_core_clk, .o_req(i_link_req));
  servo_param_fault_jog_io_bank servo_param_fault_jog_io_bank_inst (.*);
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // A read notes its expected data before the request goes out.
  task automatic xf(input logic k, input logic w, input logic [15:0] a, input logic [15:0] d);
    if (!w) exp_q.push_back(d);
    if (k) keypad_host.access(w, a, d);
    else link_host.access(w, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge i_core_clk) begin
    if (o_rvalid === 1'b1) begin
      if (exp_q.size() > 0) check("read data", exp_q.pop_front(), o_rdata);
      else check("spurious read", 16'h0000, 16'h0001);
    end
  end
  initial begin
    cyc(5);
    i_rst_b = 1'b1;
    xf(1, 0, ADDR_JOG_COMMAND, JOG_COMMAND_RESET);
    xf(0, 0, ADDR_FAULT_FIFTH_LO, 16'h0000);
    xf(0, 0, ADDR_INPUT_STATUS, SOFT_INPUT_RESET);
    xf(0, 0, ADDR_FORCED_OUTPUT, FORCED_OUTPUT_RESET);
    xf(0, 0, 16'h0500, 16'h0000);
    $display("Test reset values ended");
    xf(0, 1, ADDR_JOG_COMMAND, 16'd100);
    xf(0, 1, ADDR_JOG_COMMAND, 16'd6000);
    xf(0, 0, ADDR_JOG_COMMAND, 16'd100);
    xf(0, 1, ADDR_JOG_COMMAND, JOG_CODE_FORWARD);
    cyc(3);
    check("jog dir", 16'(JOG_FORWARD), 16'(o_jog.dir));
    check("jog speed", 16'd100, o_jog.speed);
    xf(1, 1, ADDR_JOG_COMMAND, JOG_CODE_REVERSE);
    xf(0, 1, ADDR_JOG_COMMAND, 16'd4000);
    cyc(3);
    check("jog dir", 16'(JOG_REVERSE), 16'(o_jog.dir));
    check("jog speed", i_rated_speed, o_jog.speed);
    i_fault_active = 1'b1;
    cyc(6);
    check("jog dir", 16'(JOG_IDLE), 16'(o_jog.dir));
    i_fault_active = 1'b0;
    cyc(4);
    xf(0, 1, ADDR_JOG_COMMAND, JOG_CODE_FORWARD);
    xf(0, 1, ADDR_JOG_COMMAND, JOG_CODE_STOP);
    cyc(3);
    check("jog dir", 16'(JOG_IDLE), 16'(o_jog.dir));
    $display("Test jog ended");
    i_fault_fourth = xorshift();
    i_fault_push = 1'b1;
    cyc(1);
    i_fault_push = 1'b0;
    cyc(3);
    xf(1, 0, ADDR_FAULT_FIFTH_LO, i_fault_fourth.alarm_code);
    xf(0, 0, ADDR_FAULT_FIFTH_HI, i_fault_fourth.canopen_code);
    check("fifth", i_fault_fourth.canopen_code, o_fault_record_fifth.canopen_code);
    xf(0, 1, ADDR_FAULT_FIFTH_LO, 16'h1234);
    xf(0, 0, ADDR_FAULT_FIFTH_LO, i_fault_fourth.alarm_code);
    $display("Test fault record ended");
    mask = 16'(xorshift() & 32'hff);
    i_output_normal = ~mask[4:0];
    xf(1, 1, ADDR_FORCED_OUTPUT, mask);
    xf(0, 0, ADDR_FORCED_OUTPUT, mask);
    check("outputs", {11'h0, mask[4:0]}, {11'h0, o_terminal_outputs});
    $display("Test forced outputs ended");
    i_input_soft_select = 14'h3fff;
    xf(1, 1, ADDR_INPUT_STATUS, 16'h0011);
    xf(0, 1, ADDR_INPUT_STATUS, 16'h4000);
    cyc(2);
    xf(0, 0, ADDR_INPUT_STATUS, 16'h0011);
    i_input_soft_select = '0;
    i_terminal_inputs = 14'(xorshift());
    cyc(5);
    xf(1, 0, ADDR_INPUT_STATUS, {2'b00, i_terminal_inputs});
    check("final inputs", {2'b00, i_terminal_inputs}, {2'b00, o_input_final});
    i_terminal_inputs = 14'h0001;
    cyc(4);
    i_jog_reverse_sel = 14'h0001;
    cyc(5);
    check("jog dir", 16'(JOG_REVERSE), 16'(o_jog.dir));
    $display("Test inputs ended");
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) cyc(1);
    if (exp_q.size() > 0) check("pending reads", 16'h0000, 16'(exp_q.size()));
    finish_test();
  end
endmodule
bind servo_param_fault_jog_io_bank servo_param_bank_props servo_param_bank_props_inst (
  .i_core_clk, .i_rst_b, .i_keypad_req, .i_link_req, .i_fault_push, .i_fault_active,
  .i_rated_speed, .o_rdata, .o_rvalid, .o_jog, .o_fault_record_fifth);
`default_nettype wire
